// ===== include/mhf_consts.svh
// Register offsets, field positions, reset values and timing constants
`ifndef MHF_CONSTS_SVH
`define MHF_CONSTS_SVH
`define MHF_ADDR_W         8
`define MHF_OFF_CONTROL    8'h22
`define MHF_OFF_TX_PORT    8'h23
`define MHF_OFF_RX_PORT    8'h24
`define MHF_OFF_THRESH     8'h25
`define MHF_OFF_JABBER     8'h27
`define MHF_PORT_RESET     16'h0200
`define MHF_CTRL_RESET     16'h0048
`define MHF_IRQ_MASK_RESET 16'h0024
`define MHF_CTRL_LOOP_BIT  2
`define MHF_LVL_HI         15
`define MHF_LVL_LO         12
`define MHF_LVLF_BIT       11
`define MHF_FULL_BIT       10
`define MHF_EMPTY_BIT      9
`define MHF_PAR_BIT        8
`define MHF_TH_TX_HI       7
`define MHF_TH_TX_LO       4
`define MHF_TH_RX_HI       3
`define MHF_TH_RX_LO       0
`define MHF_CLK_HZ         100000000
`define MHF_JAB_UNIT_US    2048
`define MHF_JAB_UNIT_CYC   ((`MHF_CLK_HZ / 1000000) * `MHF_JAB_UNIT_US)
`define MHF_CFG_MANCH      2'b11
`endif

// ===== include/mhf_pkg.sv
// Types shared by the host FIFO port design
package mhf_pkg;
  typedef enum logic [1:0] {MHF_FSK_1M2, MHF_FSK_3M6, MHF_MANCH} mhf_mode_t;
  typedef enum logic [1:0] {MHF_JAB_IDLE, MHF_JAB_RUN, MHF_JAB_TRIP} mhf_jab_state_t;
endpackage : mhf_pkg

// ===== logic/mhf_fifo.sv
// Fill-counted FIFO with level, full and empty status
`timescale 1ns/10ps
`include "mhf_consts.svh"
module mhf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 15,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  input  wire logic [AW-1:0]    thresh,
  output logic      [WIDTH-1:0] head_data,
  output logic      [AW-1:0]    count,
  output logic                  full,
  output logic                  empty,
  output logic                  level
);
  logic [AW-1:0] wr_q, rd_q, cnt_q;
  wire           do_push = push && (cnt_q != AW'(DEPTH)); // Full drops the write
  wire           do_pop  = pop && (cnt_q != '0);
  wire  [AW-1:0] rd_next = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
  wire  [AW-1:0] rd_look = do_pop ? rd_next : rd_q;
  // Read-during-write to the next slot must bypass the memory's old word
  wire           bypass  = do_push && (cnt_q == (do_pop ? AW'(1) : AW'(0)));
  logic [WIDTH-1:0] mem_q, byp_q;
  logic             use_byp_q;

  mhf_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk   (clk),
    .we    (do_push),
    .waddr (wr_q),
    .wdata (push_data),
    .raddr (rd_look),
    .rdata (mem_q)
  );

  // Pointers and count
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      byp_q     <= '0;
      use_byp_q <= 1'b0;
    end
    else
    begin
      if (do_push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      rd_q      <= rd_look;
      cnt_q     <= cnt_q + AW'(do_push) - AW'(do_pop);
      byp_q     <= push_data;
      use_byp_q <= bypass;
    end
  end

  assign head_data = use_byp_q ? byp_q : mem_q;
  assign count     = cnt_q;
  assign full      = (cnt_q == AW'(DEPTH));
  assign empty     = (cnt_q == '0);
  assign level     = (thresh != '0) && (cnt_q >= thresh);

  chk_full_no_grow : assert property (@(posedge clk) disable iff (!rst_n)
    full && push && !pop |=> count == AW'(DEPTH)) else $error("full FIFO grew");
endmodule : mhf_fifo

// ===== logic/mhf_host_port.sv
// Host-side transmit/receive FIFO port of the fieldbus modem
`timescale 1ns/10ps
`include "mhf_consts.svh"
module mhf_host_port
  import mhf_pkg::*;
#(
  parameter int DEPTH         = 15,
  parameter int JAB_UNIT_CYC  = `MHF_JAB_UNIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic [1:0]  clock_config_pins,
  input  wire logic        crystal_enable_pin,
  input  wire logic        demod_valid,
  input  wire logic [7:0]  demod_byte,
  input  wire logic        mod_ready,
  output logic             mod_valid,
  output logic      [8:0]  mod_byte,
  output logic             tx_active,
  output logic             jabber_trip,
  output logic             manchester_fieldbus_mode,
  output logic             use_internal_osc,
  output logic      [7:0]  fifo_events
);
  localparam int AW = 4;
  localparam int JW = 8 + $clog2(JAB_UNIT_CYC + 1);

  logic [7:0]  thresh_q, jabber_q;
  logic        loop_q;
  logic [15:0] rdata_q;
  logic        mod_valid_q;
  logic [8:0]  mod_byte_q;
  logic        manch_q, int_osc_q, trip_q, tx_active_q;
  logic [7:0]  events_q;
  logic [JW-1:0] jab_cnt_q;
  mhf_jab_state_t jab_q;

  // Address decode
  wire sel_tx   = (reg_addr == `MHF_OFF_TX_PORT);
  wire sel_rx   = (reg_addr == `MHF_OFF_RX_PORT);
  wire sel_th   = (reg_addr == `MHF_OFF_THRESH);
  wire sel_jab  = (reg_addr == `MHF_OFF_JABBER);
  wire sel_ctl  = (reg_addr == `MHF_OFF_CONTROL);

  // FIFO status
  wire [8:0]    tx_head, rx_head;
  wire [AW-1:0] tx_cnt, rx_cnt;
  wire          tx_full, tx_empty, tx_lvl, rx_full, rx_empty, rx_lvl;

  // Transmit side: host write pushes; drain to modulator or, in loopback, to receive
  wire       tx_push  = reg_wr && sel_tx;
  wire [8:0] tx_wdata = reg_wdata[`MHF_PAR_BIT:0];
  wire       tx_drain_mod  = !tx_empty && !loop_q && (!mod_valid_q || mod_ready);
  wire       tx_drain_loop = !tx_empty && loop_q && !rx_full;
  wire       tx_pop   = tx_drain_mod || tx_drain_loop;
  // Receive side: loopback replaces the demodulator source
  wire       rx_push  = loop_q ? tx_drain_loop : demod_valid;
  wire [8:0] rx_wdata = loop_q ? tx_head : {~^demod_byte, demod_byte};
  wire       rx_pop   = reg_rd && sel_rx;

  mhf_fifo #(.WIDTH(9), .DEPTH(DEPTH), .AW(AW)) u_tx (
    .clk       (clk),
    .rst_n     (rst_n),
    .push      (tx_push),
    .push_data (tx_wdata),
    .pop       (tx_pop),
    .thresh    (thresh_q[`MHF_TH_TX_HI:`MHF_TH_TX_LO]),
    .head_data (tx_head),
    .count     (tx_cnt),
    .full      (tx_full),
    .empty     (tx_empty),
    .level     (tx_lvl)
  );

  mhf_fifo #(.WIDTH(9), .DEPTH(DEPTH), .AW(AW)) u_rx (
    .clk       (clk),
    .rst_n     (rst_n),
    .push      (rx_push),
    .push_data (rx_wdata),
    .pop       (rx_pop),
    .thresh    (thresh_q[`MHF_TH_RX_HI:`MHF_TH_RX_LO]),
    .head_data (rx_head),
    .count     (rx_cnt),
    .full      (rx_full),
    .empty     (rx_empty),
    .level     (rx_lvl)
  );

  // Read data: write-only transmit fields read back as zero
  wire [15:0] tx_status = {tx_cnt, tx_lvl, tx_full, tx_empty, 9'h000};
  // Empty receive port shows zero data, matching its reset word
  wire [8:0]  rx_shown  = rx_empty ? 9'h000 : rx_head;
  wire [15:0] rx_status = {rx_cnt, rx_lvl, rx_full, rx_empty, rx_shown};
  wire [15:0] rd_mux =
    sel_tx  ? tx_status :
    sel_rx  ? rx_status :
    sel_th  ? {8'h00, thresh_q} :
    sel_jab ? {8'h00, jabber_q} :
    sel_ctl ? (16'h0001 << `MHF_CTRL_LOOP_BIT) & {16{loop_q}} :
    16'h0000;

  // Writable configuration
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      thresh_q <= 8'h00;
      jabber_q <= 8'h00;
      loop_q   <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (sel_th)
        thresh_q <= reg_wdata[7:0];
      if (sel_jab)
        jabber_q <= reg_wdata[7:0];
      if (sel_ctl)
        loop_q <= reg_wdata[`MHF_CTRL_LOOP_BIT];
    end
  end

  // Registered read data, captured on the read strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_q <= `MHF_PORT_RESET;
    else if (reg_rd)
      rdata_q <= rd_mux;
  end

  // Modulator hand-off holding register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mod_valid_q <= 1'b0;
      mod_byte_q  <= 9'h000;
    end
    else if (tx_drain_mod)
    begin
      mod_valid_q <= 1'b1;
      mod_byte_q  <= tx_head;
    end
    else if (mod_ready)
      mod_valid_q <= 1'b0;
  end

  // Mode and clock source from strap pins, sampled every cycle
  wire manch_d   = (clock_config_pins == `MHF_CFG_MANCH);
  wire int_osc_d = !crystal_enable_pin && (clock_config_pins != `MHF_CFG_MANCH);

  // Jabber: counts continuous transmission in 2.048 ms units; zero disables
  wire busy     = mod_valid_q || !tx_empty;
  wire unit_end = (jab_cnt_q[JW-9:0] == (JW-8)'(JAB_UNIT_CYC - 1));
  wire units_up = (jab_cnt_q[JW-1:JW-8] == jabber_q - 8'h01);
  always_ff @(posedge clk)
  begin
    if (!rst_n || !busy || jabber_q == 8'h00)
    begin
      jab_q     <= MHF_JAB_IDLE;
      jab_cnt_q <= '0;
    end
    else
    begin
      unique case (jab_q)
        MHF_JAB_IDLE: jab_q <= MHF_JAB_RUN;
        MHF_JAB_RUN:
        begin
          if (unit_end && units_up)
            jab_q <= MHF_JAB_TRIP;
          else if (unit_end)
            jab_cnt_q <= {jab_cnt_q[JW-1:JW-8] + 8'h01, (JW-8)'(0)};
          else
            jab_cnt_q <= jab_cnt_q + JW'(1);
        end
        MHF_JAB_TRIP: jab_q <= MHF_JAB_TRIP;
      endcase
    end
  end

  // Output flops: mode pins, jabber, and FIFO events for the interrupt logic
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      manch_q     <= 1'b0;
      int_osc_q   <= 1'b0;
      trip_q      <= 1'b0;
      tx_active_q <= 1'b0;
      events_q    <= 8'h00;
    end
    else
    begin
      manch_q     <= manch_d;
      int_osc_q   <= int_osc_d;
      trip_q      <= (jab_q == MHF_JAB_TRIP);
      tx_active_q <= busy;
      // Unmasked event levels; the status register sees them regardless of mask
      events_q    <= {rx_lvl, rx_full, rx_empty, tx_lvl, tx_full, tx_empty, 2'b00};
    end
  end

  assign reg_rdata                = rdata_q;
  assign mod_valid                = mod_valid_q;
  assign mod_byte                 = mod_byte_q;
  assign tx_active                = tx_active_q;
  assign jabber_trip              = trip_q;
  assign manchester_fieldbus_mode = manch_q;
  assign use_internal_osc         = int_osc_q;
  assign fifo_events              = events_q;

  sequence s_rx_read;
    reg_rd && sel_rx && !rx_empty;
  endsequence
  chk_rx_pop_one : assert property (@(posedge clk) disable iff (!rst_n)
    s_rx_read and (!rx_push) |=> rx_cnt == $past(rx_cnt) - 4'h1) else $error("rx pop");
  chk_tx_empty_read : assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && sel_tx |=> reg_rdata[`MHF_EMPTY_BIT] == $past(tx_empty)) else $error("empty");
  chk_level_flag : assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && sel_rx |=> reg_rdata[`MHF_LVLF_BIT] ==
      ($past(rx_cnt) >= $past(thresh_q[3:0]) && $past(thresh_q[3:0]) != 0))
    else $error("level");
  chk_count_field : assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && sel_tx |=> reg_rdata[`MHF_LVL_HI:`MHF_LVL_LO] == $past(tx_cnt))
    else $error("count");
  chk_full_flag : assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && sel_rx |=> reg_rdata[`MHF_FULL_BIT] == ($past(rx_cnt) == 4'(DEPTH)))
    else $error("full");
  chk_rx_parity : assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && sel_rx && !rx_empty |=> ^reg_rdata[8:0] == 1'b1 || $past(loop_q))
    else $error("parity");
  chk_tx_push : assert property (@(posedge clk) disable iff (!rst_n)
    tx_push && !tx_full && !tx_pop |=> tx_cnt == $past(tx_cnt) + 4'h1)
    else $error("tx push");
  chk_loop_route : assert property (@(posedge clk) disable iff (!rst_n)
    loop_q |=> !mod_valid || $past(mod_valid)) else $error("loopback");
  chk_mode_pin : assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> manchester_fieldbus_mode == $past(manch_d)) else $error("mode");
endmodule : mhf_host_port

// ===== logic/mhf_mem.sv
// Small memory for FIFO entries with registered read data
`timescale 1ns/10ps
module mhf_mem #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 15,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // No reset on storage: contents only matter once written
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : mhf_mem

// ===== tb/mhf_mod_model.sv
// Modulator-side partner that takes transmit bytes promptly, slowly or not at all
`timescale 1ns/10ps
module mhf_mod_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic hold,
  input  wire logic slow,
  output logic      mod_ready
);
  logic ready_q;
  // Slow mode drops ready every other cycle, so a byte may wait on the link
  always_ff @(posedge clk)
  begin
    if (!rst_n || hold)
      ready_q <= 1'b0;
    else
      ready_q <= slow ? ~ready_q : 1'b1;
  end
  assign mod_ready = ready_q;
endmodule : mhf_mod_model

// ===== tb/tb_top.sv
// Self-checking bench for the host FIFO port
`timescale 1ns/10ps
`include "mhf_consts.svh"
module tb_top
  import mhf_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        crystal_enable_pin = 1'b0, demod_valid = 1'b0, hold = 1'b1, slow = 1'b0;
  logic [7:0]  reg_addr = 8'h00, demod_byte = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [1:0]  clock_config_pins = 2'b00;
  logic [15:0] reg_rdata;
  logic        mod_ready, mod_valid, tx_active, jabber_trip;
  logic        manchester_fieldbus_mode, use_internal_osc, rd_seen = 1'b0;
  logic [8:0]  mod_byte;
  logic [7:0]  fifo_events;
  logic [7:0]  rx[16];
  logic [8:0]  lb[3];
  logic [31:0] seed = 32'd54, d, e;
  logic [31:0] rq[$];
  logic [8:0]  mq[$];
  int          n_errors = 0, check_count = 0, cycles = 0, i, k;

  mhf_host_port #(.JAB_UNIT_CYC(4)) mhf_host_port_inst (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .clock_config_pins(clock_config_pins),
    .crystal_enable_pin(crystal_enable_pin), .demod_valid(demod_valid),
    .demod_byte(demod_byte), .mod_ready(mod_ready), .mod_valid(mod_valid),
    .mod_byte(mod_byte), .tx_active(tx_active), .jabber_trip(jabber_trip),
    .manchester_fieldbus_mode(manchester_fieldbus_mode),
    .use_internal_osc(use_internal_osc), .fifo_events(fifo_events));
  mhf_mod_model mhf_mod_model_inst (.clk(clk), .rst_n(rst_n), .hold(hold), .slow(slow),
    .mod_ready(mod_ready));

  always #5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] msk);
    check_count++;
    if ((got & msk) !== (exp & msk))
    begin
      n_errors++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_pin(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask : chk_pin

  // Register strobes last one cycle; the design takes them at the next edge
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] v, input logic [15:0] msk);
    rq.push_back({msk, v});
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic finish_test();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Monitor: read data one cycle after the taken read, bytes at each hand-off
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rd_seen && rq.size() > 0)
    begin
      e = rq.pop_front();
      chk(reg_rdata, e[15:0], e[31:16]);
    end
    rd_seen <= reg_rd;
    if (mod_valid === 1'b1 && mod_ready === 1'b1) // Unexpected byte always mismatches
      chk({7'h00, mod_byte}, mq.size() ? {7'h00, mq.pop_front()} : 16'hffff, 16'hffff);
    if (cycles == 20000)
    begin
      n_errors++;
      finish_test();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(16'(fifo_events), 16'h0024, 16'hffff);
    rd(`MHF_OFF_TX_PORT, 16'h0200, 16'hffff);
    rd(`MHF_OFF_RX_PORT, 16'h0200, 16'hffff);
    rd(`MHF_OFF_CONTROL, 16'h0000, 16'hffff);
    rd(8'h30, 16'h0000, 16'hffff);
    wr(`MHF_OFF_THRESH, 16'hff57);
    rd(`MHF_OFF_THRESH, 16'h0057, 16'hffff);
    wr(`MHF_OFF_JABBER, 16'hab00);
    rd(`MHF_OFF_JABBER, 16'h0000, 16'hffff);
    wr(`MHF_OFF_RX_PORT, 16'hffff);
    rd(`MHF_OFF_RX_PORT, 16'h0200, 16'hffff);
    $display("Test registers done");
    // Stalled modulator: first byte sits in hand-off, FIFO fills to 15, extra dropped
    for (i = 1; i <= 17; i++)
    begin
      d = rnd();
      wr(`MHF_OFF_TX_PORT, {7'h7f, ~^d[7:0], d[7:0]});
      if (i <= 16)
        mq.push_back({~^d[7:0], d[7:0]});
      repeat (3) @(posedge clk);
      k = (i > 16) ? 15 : i - 1;
      rd(`MHF_OFF_TX_PORT, {k[3:0], k >= 5, k == 15, k == 0, 9'h000}, 16'hffff);
    end
    chk(16'(fifo_events[4:2]), 16'h0006, 16'hffff);
    chk_pin(jabber_trip, 1'b0);
    slow <= 1'b1;
    hold <= 1'b0;
    repeat (60) @(posedge clk);
    chk_pin(mq.size() == 0, 1'b1);
    chk_pin(tx_active, 1'b0);
    $display("Test transmit fill done");
    // Jabber: 2 units of 4 cycles while the link stalls
    wr(`MHF_OFF_JABBER, 16'h0002);
    hold <= 1'b1;
    wr(`MHF_OFF_TX_PORT, 16'h0155);
    mq.push_back(9'h155);
    repeat (4) @(posedge clk);
    chk_pin(jabber_trip, 1'b0);
    chk_pin(tx_active, 1'b1);
    repeat (16) @(posedge clk);
    chk_pin(jabber_trip, 1'b1);
    hold <= 1'b0;
    repeat (10) @(posedge clk);
    chk_pin(jabber_trip, 1'b0);
    $display("Test jabber done");
    // Loopback carries the host parity bit unchanged into the receive FIFO
    wr(`MHF_OFF_CONTROL, 16'h0004);
    rd(`MHF_OFF_CONTROL, 16'h0004, 16'hffff);
    for (i = 0; i < 3; i++)
    begin
      d = rnd();
      lb[i] = d[8:0];
      wr(`MHF_OFF_TX_PORT, {7'h00, d[8:0]});
    end
    repeat (8) @(posedge clk);
    for (i = 0; i < 3; i++)
      rd(`MHF_OFF_RX_PORT, {7'h00, lb[i]}, 16'h01ff);
    wr(`MHF_OFF_CONTROL, 16'h0000);
    $display("Test loopback done");
    // Receive fill back to back, sixteenth byte dropped, then drain past empty
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      d = rnd();
      demod_valid <= 1'b1;
      demod_byte <= d[7:0];
      if (i < 15)
        rx[i] = d[7:0];
    end
    @(posedge clk);
    demod_valid <= 1'b0;
    repeat (2) @(posedge clk);
    chk(16'(fifo_events), 16'h00c4, 16'hffff);
    for (i = 0; i < 16; i++)
    begin
      k = 15 - i;
      rd(`MHF_OFF_RX_PORT, (i < 15) ? {k[3:0], k >= 7, k == 15, 1'b0, ~^rx[i], rx[i]}
         : 16'h0200, 16'hffff);
    end
    $display("Test receive fill done");
    // Every strap combination
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk);
      clock_config_pins <= i[1:0];
      crystal_enable_pin <= i[2];
      repeat (3) @(posedge clk);
      chk_pin(manchester_fieldbus_mode, i[1:0] == 2'b11);
      chk_pin(use_internal_osc, !i[2] && i[1:0] != 2'b11);
    end
    $display("Test straps done");
    // Second reset in mid-run empties the transmit side
    hold <= 1'b1;
    wr(`MHF_OFF_TX_PORT, 16'h0080);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(`MHF_OFF_TX_PORT, 16'h0200, 16'hffff);
    repeat (3) @(posedge clk);
    $display("Test second reset done");
    finish_test();
  end
endmodule : tb_top
